// ### verilog/monitor_pkg.sv
// shared constants and types for the supply monitor control block
package monitor_pkg;
  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_CTRL_A = 6'h00;
  localparam logic [5:0] IDX_CTRL_B = 6'h01;
  localparam logic [5:0] IDX_WARN_CTRL = 6'h08;
  localparam logic [5:0] IDX_IRQ_CTRL = 6'h09;
  localparam logic [5:0] IDX_IRQ_FLAGS = 6'h0A;
  localparam logic [5:0] IDX_STATUS = 6'h0B;
  localparam logic [5:0] IDX_GUARD = 6'h0C;
  // monitor_control_a fields
  localparam int SLEEP_LSB = 0;
  localparam int ACTIVE_LSB = 2;
  localparam int SAMPFREQ_BIT = 4;
  // irq_control fields
  localparam int IE_BIT = 0;
  localparam int TRIG_LSB = 1;
  // irq_flags and status fields
  localparam int FLAG_BIT = 0;
  localparam int WSTAT_BIT = 0;
  // field widths and reset values
  localparam int MODE_W = 2;
  localparam int LVL_W = 3;
  localparam int WLVL_W = 2;
  localparam logic [1:0] WLVL_RST = 2'h0;
  localparam logic [1:0] TRIG_RST = 2'h0;
  // unlock key, arbitrary value
  localparam logic [7:0] UNLOCK_KEY = 8'hA5;
  // timing
  localparam longint CLK_HZ = 40000000;
  localparam longint CLK_NS = 25;
  localparam longint SAMP_FAST_HZ = 1000;
  localparam longint SAMP_SLOW_HZ = 125;
  localparam int SAMP_FAST_CYC = int'(CLK_HZ / SAMP_FAST_HZ);
  localparam int SAMP_SLOW_CYC = int'(CLK_HZ / SAMP_SLOW_HZ);
  localparam longint SAMP_ON_NS = 500;
  localparam int SAMP_ON_CYC = int'((SAMP_ON_NS + CLK_NS - 1) / CLK_NS);
  localparam longint WAKE_SETTLE_NS = 1000;
  localparam int WAKE_CYC = int'((WAKE_SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam int GUARD_CYC = 4;
  localparam int CNT_W = 19;
  // operating modes
  typedef enum logic [1:0] {
    MODE_DIS = 2'b00,
    MODE_CONT = 2'b01,
    MODE_SAMP = 2'b10,
    MODE_WAKE = 2'b11
  } mode_t;
  // warning trigger selections
  typedef enum logic [1:0] {
    TRIG_BELOW = 2'b00,
    TRIG_ABOVE = 2'b01,
    TRIG_CROSS = 2'b10,
    TRIG_RSVD = 2'b11
  } trig_t;
  // sample sequencer states
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_WAIT = 2'b01,
    ST_ON = 2'b10
  } samp_state_t;
endpackage

// ### verilog/monitor_sync.sv
// two stage synchroniser for comparator levels
`timescale 1ns/1ps
module monitor_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // one pair of flops per bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= d[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign q = sync_reg;
endmodule

// ### verilog/brownout_supply_monitor_ctrl.sv
// supply monitor control: modes, sampling, reset, early warning, apb
`timescale 1ns/1ps
module brownout_supply_monitor_ctrl #(
  parameter int SAMP_FAST_CYC = monitor_pkg::SAMP_FAST_CYC,
  parameter int SAMP_SLOW_CYC = monitor_pkg::SAMP_SLOW_CYC
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [monitor_pkg::ADDR_W-1:0] PADDR,
  input wire logic [monitor_pkg::DATA_W-1:0] PWDATA,
  output logic [monitor_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // fuse configuration
  input wire logic [monitor_pkg::MODE_W-1:0] FUSE_ACTIVE,
  input wire logic [monitor_pkg::MODE_W-1:0] FUSE_SLEEP,
  input wire logic FUSE_SAMPFREQ,
  input wire logic [monitor_pkg::LVL_W-1:0] FUSE_LEVEL,
  // system state
  input wire logic DEEP_SLEEP,
  input wire logic DEBUG_HALT,
  // analog comparator results, high when supply below
  input wire logic BOD_BELOW,
  input wire logic WARN_BELOW,
  // analog control
  output logic BOD_ENABLE,
  output logic [monitor_pkg::LVL_W-1:0] BOD_LEVEL,
  output logic WARN_ENABLE,
  output logic [monitor_pkg::WLVL_W-1:0] WARN_LEVEL,
  // system outputs
  output logic SYS_RESET_REQ,
  output logic WAKE_HOLD,
  output logic WARN_IRQ
);
  import monitor_pkg::*;

  // configuration registers
  logic [1:0] active_reg;
  logic [1:0] sleep_reg;
  logic sampfreq_reg;
  logic [2:0] lvl_reg;
  logic [1:0] wlvl_reg;
  logic [1:0] trig_reg;
  logic ie_reg;
  // state registers
  logic flag_reg;
  logic wstat_reg;
  logic reset_req_reg;
  logic [2:0] guard_reg;
  logic deep_q_reg;
  logic [5:0] hold_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  samp_state_t state_reg;
  samp_state_t state_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;

  // synchronised comparator levels
  logic bod_below_s;
  logic warn_below_s;

  monitor_sync #(.W(2)) u_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .d({BOD_BELOW, WARN_BELOW}),
    .q({bod_below_s, warn_below_s})
  );

  // apb decode
  wire [5:0] idx = PADDR[7:2];
  wire aligned = PADDR[1:0] == 2'b00;
  wire hit_a = aligned && idx == IDX_CTRL_A;
  wire hit_b = aligned && idx == IDX_CTRL_B;
  wire hit_wc = aligned && idx == IDX_WARN_CTRL;
  wire hit_ic = aligned && idx == IDX_IRQ_CTRL;
  wire hit_if = aligned && idx == IDX_IRQ_FLAGS;
  wire hit_st = aligned && idx == IDX_STATUS;
  wire hit_g = aligned && idx == IDX_GUARD;
  wire hit_any = hit_a | hit_b | hit_wc | hit_ic | hit_if | hit_st | hit_g;
  wire access = PSEL && PENABLE;
  wire wr = access && PWRITE && hit_any;
  wire setup_rd = PSEL && !PENABLE && !PWRITE;

  // single cycle access phase, error on unmapped address
  assign PREADY = 1'b1;
  assign PSLVERR = access && !hit_any;
  assign PRDATA = prdata_reg;

  // unlock window and protected write
  wire guard_open = guard_reg != 3'h0;
  wire key_wr = wr && hit_g && PWDATA[7:0] == UNLOCK_KEY;
  wire ctrl_wr = wr && hit_a;
  wire prot_wr = ctrl_wr && guard_open;
  wire flag_clr = wr && hit_if && PWDATA[FLAG_BIT];

  // effective mode, reserved sleep code acts as disabled
  wire [1:0] sleep_mode = (sleep_reg == MODE_WAKE) ? MODE_DIS : sleep_reg;
  wire [1:0] mode_eff = DEEP_SLEEP ? sleep_mode : active_reg;
  wire mode_cont = mode_eff == MODE_CONT || mode_eff == MODE_WAKE;
  wire mode_samp = mode_eff == MODE_SAMP;
  wire mode_on = mode_cont || mode_samp;

  // sampling period chosen by frequency bit
  wire [CNT_W-1:0] period_last = sampfreq_reg ?
    CNT_W'(SAMP_SLOW_CYC - 1) : CNT_W'(SAMP_FAST_CYC - 1);
  wire [CNT_W-1:0] on_last = CNT_W'(SAMP_ON_CYC - 1);
  wire sample_take = state_reg == ST_ON && cnt_reg == on_last;
  wire measure = mode_cont || sample_take;

  // warning monitor follows the monitor mode and the enable bit
  wire warn_active = ie_reg && mode_on;
  wire warn_meas = warn_active && measure;
  wire fall = warn_meas && warn_below_s && !wstat_reg;
  wire rise = warn_meas && !warn_below_s && wstat_reg;
  logic warn_event;

  // trigger selection
  always_comb begin
    case (trig_t'(trig_reg))
      TRIG_BELOW: warn_event = fall;
      TRIG_ABOVE: warn_event = rise;
      TRIG_CROSS: warn_event = fall || rise;
      default: warn_event = 1'b0;
    endcase
  end

  // sample sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + CNT_W'(1);
    case (state_reg)
      ST_OFF: begin
        cnt_next = '0;
        if (mode_samp) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt_reg >= period_last) begin
          state_next = ST_ON;
          cnt_next = '0;
        end
      end
      ST_ON: begin
        if (cnt_reg == on_last) begin
          state_next = ST_WAIT;
          cnt_next = on_last + CNT_W'(1);
        end
      end
      default: begin
        state_next = ST_OFF;
        cnt_next = '0;
      end
    endcase
    if (!mode_samp) begin
      state_next = ST_OFF;
      cnt_next = '0;
    end
  end

  // sequencer registers
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_reg <= ST_OFF;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // fuse loaded configuration, threshold and active mode never written
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      active_reg <= FUSE_ACTIVE;
      sampfreq_reg <= FUSE_SAMPFREQ;
      lvl_reg <= FUSE_LEVEL;
    end
  end

  // sleep mode from fuses, changed only after unlock
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sleep_reg <= FUSE_SLEEP;
    end else if (prot_wr) begin
      sleep_reg <= PWDATA[SLEEP_LSB +: 2];
    end
  end

  // unlock window counts down, closes on protected write
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      guard_reg <= 3'h0;
    end else if (key_wr) begin
      guard_reg <= 3'(GUARD_CYC);
    end else if (prot_wr) begin
      guard_reg <= 3'h0;
    end else if (guard_open) begin
      guard_reg <= guard_reg - 3'h1;
    end
  end

  // warning control registers
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      wlvl_reg <= WLVL_RST;
      trig_reg <= TRIG_RST;
      ie_reg <= 1'b0;
    end else begin
      if (wr && hit_wc) begin
        wlvl_reg <= PWDATA[1:0];
      end
      if (wr && hit_ic) begin
        ie_reg <= PWDATA[IE_BIT];
        trig_reg <= PWDATA[TRIG_LSB +: 2];
      end
    end
  end

  // warning status and flag, a new event beats the clear
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      wstat_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      if (warn_meas) begin
        wstat_reg <= warn_below_s;
      end
      flag_reg <= warn_event || (flag_reg && !flag_clr);
    end
  end

  // reset request updated at each measurement
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      reset_req_reg <= 1'b0;
    end else if (!mode_on) begin
      reset_req_reg <= 1'b0;
    end else if (measure) begin
      reset_req_reg <= bod_below_s;
    end
  end

  // hold execution after wake until the monitor has settled
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      deep_q_reg <= 1'b0;
      hold_reg <= 6'h00;
    end else begin
      deep_q_reg <= DEEP_SLEEP;
      if (deep_q_reg && !DEEP_SLEEP && active_reg == MODE_WAKE) begin
        hold_reg <= 6'(WAKE_CYC);
      end else if (hold_reg != 6'h00) begin
        hold_reg <= hold_reg - 6'h01;
      end
    end
  end

  // read data captured in the setup phase
  always_comb begin
    prdata_next = '0;
    if (hit_a) begin
      prdata_next[SLEEP_LSB +: 2] = sleep_reg;
      prdata_next[ACTIVE_LSB +: 2] = active_reg;
      prdata_next[SAMPFREQ_BIT] = sampfreq_reg;
    end
    if (hit_b) begin
      prdata_next[2:0] = lvl_reg;
    end
    if (hit_wc) begin
      prdata_next[1:0] = wlvl_reg;
    end
    if (hit_ic) begin
      prdata_next[IE_BIT] = ie_reg;
      prdata_next[TRIG_LSB +: 2] = trig_reg;
    end
    if (hit_if) begin
      prdata_next[FLAG_BIT] = flag_reg;
    end
    if (hit_st) begin
      prdata_next[WSTAT_BIT] = wstat_reg;
    end
    if (hit_g) begin
      prdata_next[0] = guard_open;
    end
  end

  // read data register
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      prdata_reg <= '0;
    end else if (setup_rd) begin
      prdata_reg <= prdata_next;
    end
  end

  // analog control and system outputs
  assign BOD_ENABLE = mode_cont || (mode_samp && state_reg == ST_ON);
  assign BOD_LEVEL = lvl_reg;
  assign WARN_ENABLE = warn_active && BOD_ENABLE;
  assign WARN_LEVEL = wlvl_reg;
  assign SYS_RESET_REQ = reset_req_reg;
  assign WAKE_HOLD = hold_reg != 6'h00;
  assign WARN_IRQ = flag_reg && ie_reg && !DEBUG_HALT;

  // checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  sequence s_key_then_write;
    key_wr ##1 (!key_wr && !prot_wr) [*2] ##1 prot_wr;
  endsequence

  sequence s_locked_write;
    ctrl_wr && !guard_open;
  endsequence

  a_reset_on_below: assert property (
    (mode_on && measure && bod_below_s) |=> SYS_RESET_REQ)
    else $error("reset not raised on low supply");

  a_warn_off_dis: assert property (
    !mode_on |-> !WARN_ENABLE && !warn_event)
    else $error("warning active while monitor disabled");

  a_warn_sampled: assert property (
    (mode_samp && WARN_ENABLE) |-> state_reg == ST_ON)
    else $error("warning on outside sample window");

  a_fuse_load: assert property (
    $fell(SYS_RST) |-> active_reg == $past(FUSE_ACTIVE) &&
      lvl_reg == $past(FUSE_LEVEL) && sleep_reg == $past(FUSE_SLEEP))
    else $error("fuse values not loaded");

  a_level_fixed: assert property (
    !SYS_RST |=> $stable(lvl_reg) && $stable(active_reg))
    else $error("fixed field changed");

  a_locked_sleep: assert property (
    s_locked_write |=> $stable(sleep_reg))
    else $error("protected field written while locked");

  a_unlock_write: assert property (
    s_key_then_write |=> sleep_reg == $past(PWDATA[1:0]))
    else $error("unlocked write not applied");

  a_flag_set: assert property (
    warn_event |=> flag_reg)
    else $error("flag not set on trigger");

  a_flag_hold: assert property (
    (flag_reg && !flag_clr) |=> flag_reg)
    else $error("flag dropped without clear");

  a_irq_debug: assert property (
    DEBUG_HALT |-> !WARN_IRQ)
    else $error("interrupt during debug halt");

  a_sleep_mode: assert property (
    (DEEP_SLEEP && sleep_reg == MODE_DIS) |-> !BOD_ENABLE)
    else $error("monitor on in disabled sleep");

  a_sync_delay: assert property (
    $past(SYS_RST, 2) == 1'b0 |-> bod_below_s == $past(BOD_BELOW, 2))
    else $error("comparator sync latency wrong");

  a_sample_len: assert property (
    $rose(state_reg == ST_ON) |-> (state_reg == ST_ON || !mode_samp) [*8])
    else $error("sample window too short");

endmodule

// ### test/supply_model.sv
// supply and comparator model facing the monitor's analog pins
`timescale 1ns/1ps
module supply_model #(
  parameter int BASE_MV = 1800,
  parameter int STEP_MV = 200
) (
  // clock
  input wire logic clk,
  // analog control from the monitor
  input wire logic bod_en,
  input wire logic [2:0] bod_lvl,
  input wire logic warn_en,
  input wire logic [1:0] warn_lvl,
  // supply level in millivolts
  input wire logic [15:0] supply_mv,
  // comparator results, high when supply below
  output logic bod_below,
  output logic warn_below
);
  int bod_thr;
  int warn_thr;
  logic toggle_reg = 1'b0;
  // thresholds from the level codes
  assign bod_thr = BASE_MV + STEP_MV * int'(bod_lvl);
  assign warn_thr = bod_thr * (105 + 10 * int'(warn_lvl)) / 100;
  // a switched-off comparator gives no valid level
  always @(posedge clk) begin
    toggle_reg <= ~toggle_reg;
  end
  // comparator outputs
  assign bod_below = bod_en ? (int'(supply_mv) < bod_thr) : toggle_reg;
  assign warn_below = warn_en ? (int'(supply_mv) < warn_thr) : ~toggle_reg;
endmodule

// ### test/brownout_supply_monitor_ctrl_tb.sv
// self-checking bench for the supply monitor control block
`timescale 1ns/1ps
module brownout_supply_monitor_ctrl_tb;
  import monitor_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  logic [1:0] f_act = 2'h1, f_slp = 2'h1;
  logic f_freq = 1'b0, deep = 1'b0, dbg = 1'b0;
  logic [2:0] f_lvl = 3'h0, bod_lvl;
  logic bod_below, warn_below, bod_en, warn_en, rst_req, wake_hold, irq;
  logic [1:0] warn_lvl;
  logic [15:0] supply = 16'h1388;
  int error_cnt = 0, samples_checked = 0, cycles = 0;
  int m_act, m_slp, m_freq, m_lvl, m_wl, bt, wt, hi, mid, ex, cnt, bad;
  // clock and timeout
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  // design and far-side model
  brownout_supply_monitor_ctrl #(.SAMP_FAST_CYC(64), .SAMP_SLOW_CYC(128)) uut (
    .CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FUSE_ACTIVE(f_act), .FUSE_SLEEP(f_slp), .FUSE_SAMPFREQ(f_freq), .FUSE_LEVEL(f_lvl),
    .DEEP_SLEEP(deep), .DEBUG_HALT(dbg), .BOD_BELOW(bod_below), .WARN_BELOW(warn_below),
    .BOD_ENABLE(bod_en), .BOD_LEVEL(bod_lvl), .WARN_ENABLE(warn_en), .WARN_LEVEL(warn_lvl),
    .SYS_RESET_REQ(rst_req), .WAKE_HOLD(wake_hold), .WARN_IRQ(irq));
  supply_model sm (.clk(clk), .bod_en(bod_en), .bod_lvl(bod_lvl), .warn_en(warn_en),
    .warn_lvl(warn_lvl), .supply_mv(supply), .bod_below(bod_below), .warn_below(warn_below));
  // compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one apb transfer, held until pready
  task apb(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [5:0] idx, input int e);
    apb(1'b0, idx, 32'h0000_0000);
    check(rd, 32'(e), "register read");
    check(32'(er), 32'h0000_0000, "read error flag");
  endtask
  task unlock_sleep(input int s);
    apb(1'b1, IDX_GUARD, 32'(UNLOCK_KEY));
    apb(1'b1, IDX_CTRL_A, 32'(s));
    m_slp = s;
  endtask
  task do_reset;
    rst <= 1'b1;
    cyc(5);
    rst <= 1'b0;
    m_act = f_act;
    m_slp = f_slp;
    m_freq = f_freq;
    m_lvl = f_lvl;
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(34300));
    f_act = 2'($urandom_range(3, 0));
    f_slp = 2'($urandom_range(2, 0));
    f_freq = 1'($urandom_range(1, 0));
    f_lvl = 3'($urandom_range(7, 0));
    do_reset();
    rdchk(IDX_CTRL_A, m_freq * 16 + m_act * 4 + m_slp);
    rdchk(IDX_CTRL_B, m_lvl);
    check(32'(bod_lvl), 32'(m_lvl), "threshold code");
    $display("fuse load test done");
    f_act <= 2'h1;
    f_slp <= 2'h1;
    f_freq <= 1'b0;
    do_reset();
    apb(1'b1, IDX_CTRL_A, 32'h0000_001C);
    apb(1'b1, IDX_CTRL_B, 32'h0000_0007);
    rdchk(IDX_CTRL_A, 4 + m_slp);
    rdchk(IDX_CTRL_B, m_lvl);
    unlock_sleep($urandom_range(2, 0));
    rdchk(IDX_CTRL_A, 4 + m_slp);
    apb(1'b1, IDX_GUARD, 32'(UNLOCK_KEY));
    cyc(6);
    apb(1'b1, IDX_CTRL_A, 32'((m_slp + 1) % 3));
    rdchk(IDX_CTRL_A, 4 + m_slp);
    apb(1'b0, 6'h3F, 32'h0000_0000);
    check({31'h0, er}, 32'h0000_0001, "unmapped error");
    check(rd, 32'h0000_0000, "unmapped read");
    $display("register access test done");
    bt = 1800 + 200 * m_lvl;
    supply <= 16'(bt - 100);
    for (int i = 0; i < 12 && rst_req !== 1'b1; i++) @(posedge clk);
    check({31'h0, rst_req}, 32'h0000_0001, "reset raised");
    supply <= 16'h1388;
    for (int i = 0; i < 12 && rst_req !== 1'b0; i++) @(posedge clk);
    check({31'h0, rst_req}, 32'h0000_0000, "reset released");
    $display("brown-out reset test done");
    m_wl = $urandom_range(2, 0);
    apb(1'b1, IDX_WARN_CTRL, 32'(m_wl));
    rdchk(IDX_WARN_CTRL, m_wl);
    check(32'(warn_lvl), 32'(m_wl), "warning level");
    wt = bt * (105 + 10 * m_wl) / 100;
    hi = wt + 200;
    mid = (bt + wt) / 2;
    supply <= 16'(hi);
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, IDX_IRQ_CTRL, 32'(1 + 2 * t));
      cyc(8);
      apb(1'b1, IDX_IRQ_FLAGS, 32'h0000_0001);
      for (int d = 0; d < 2; d++) begin
        supply <= 16'(d ? hi : mid);
        cyc(8);
        ex = (t == 2 || t == d) ? 1 : 0;
        check({31'h0, irq}, 32'(ex), "warning request");
        rdchk(IDX_IRQ_FLAGS, ex);
        rdchk(IDX_STATUS, 1 - d);
        if (ex == 1) begin
          dbg <= 1'b1;
          cyc(1);
          check({31'h0, irq}, 32'h0000_0000, "request in debug halt");
          dbg <= 1'b0;
          apb(1'b1, IDX_IRQ_FLAGS, 32'h0000_0001);
          cyc(1);
          check({31'h0, irq}, 32'h0000_0000, "request after clear");
        end
      end
    end
    apb(1'b1, IDX_IRQ_CTRL, 32'h0000_0004);
    supply <= 16'(mid);
    cyc(8);
    check({31'h0, warn_en}, 32'h0000_0000, "warning off");
    rdchk(IDX_IRQ_FLAGS, 0);
    $display("early warning test done");
    unlock_sleep(0);
    apb(1'b1, IDX_IRQ_CTRL, 32'h0000_0001);
    deep <= 1'b1;
    cyc(4);
    check({31'h0, bod_en}, 32'h0000_0000, "monitor off in sleep");
    check({31'h0, warn_en}, 32'h0000_0000, "warning off in sleep");
    unlock_sleep(2);
    cnt = 0;
    bad = 0;
    repeat (192) begin
      @(posedge clk);
      cnt += bod_en;
      bad += warn_en & ~bod_en;
    end
    check(32'(cnt >= 40 && cnt <= 80), 32'h0000_0001, "sampled on time");
    check(32'(bad), 32'h0000_0000, "warning outside samples");
    deep <= 1'b0;
    cyc(4);
    check({31'h0, bod_en}, 32'h0000_0001, "monitor on after wake");
    check({31'h0, wake_hold}, 32'h0000_0000, "no hold in continuous mode");
    $display("sleep mode test done");
    finish_test();
  end
endmodule
